/* rtl/emitter_range_defs.vh */
// Constants for the emitter range and converter subrange override registers
// Assumes an 8-bit register port with byte offsets as addresses
`ifndef EMITTER_RANGE_DEFS_VH
`define EMITTER_RANGE_DEFS_VH
`define ADDR_W 8
`define DATA_W 8
`define OFS_EMITTER_RANGE 8'h2a
`define OFS_EXP1_OVERRIDE 8'h2c
`define OFS_EXP6_OVERRIDE 8'h31
`define RST_BYTE 8'h00
`define RANGE_MASK 8'h3f
`define OVR_MASK 8'hbf
`define OVR_BIT 7
`define CODE_MSB 5
`define RANGE1_LSB 0
`define RANGE2_LSB 2
`define RANGE3_LSB 4
`define NUM_EXPOSURES 6
`define EXP_IDX_W 3
// Current step per amplitude LSB, in units of 0.12 mA, indexed by range
`define STEP_UNITS_W 3
`define CURRENT_W 11
`define OFS_EXP2_OVERRIDE 8'h2d
`define OFS_EXP3_OVERRIDE 8'h2e
`define OFS_EXP4_OVERRIDE 8'h2f
`define OFS_EXP5_OVERRIDE 8'h30
// Storage slot of each exposure's override register
`define SLOT1 0
`define SLOT2 1
`define SLOT3 2
`define SLOT4 3
`define SLOT5 4
`define SLOT6 5
// Exposure numbers as the sequencer presents them
`define EXP_NUM1 3'h1
`define EXP_NUM2 3'h2
`define EXP_NUM3 3'h3
`define EXP_NUM4 3'h4
`define EXP_NUM5 3'h5
`define EXP_NUM6 3'h6
`define DAC_RST 6'h00
`define SW_RST 1'b0
`define RANGE_RST 6'h00
`define STEP_ONE 3'h1
`endif

/* rtl/emitter_current_calc.v */
// One emitter driver: range code and amplitude give nominal current
// Assumes amplitude code comes from a register held elsewhere
`timescale 1ns/100ps
`default_nettype none
`include "emitter_range_defs.vh"
module emitter_current_calc
(
    input wire [1:0] i_range,
    input wire [7:0] i_amplitude,
    output wire [`CURRENT_W-1:0] o_current_units,
    output wire [1:0] o_full_scale_units
);
    // Step is (range+1) * 0.12 mA, so full scale is (range+1) * 30.6 mA
    wire [`STEP_UNITS_W-1:0] step_units;
    assign step_units = {1'b0, i_range} + `STEP_ONE;
    // Both factors widened first so the product keeps all eleven bits
    assign o_current_units = {3'h0, i_amplitude} * {8'h00, step_units};
    assign o_full_scale_units = i_range;
endmodule // emitter_current_calc
`default_nettype wire

/* rtl/emitter_range_regs.v */
// Emitter range select and per-exposure subrange DAC override registers
// Assumes a same-clock register port and an exposure sequencer that
// pulses I_CONV_START with the exposure index before each conversion
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "emitter_range_defs.vh"
module emitter_range_regs
(
    input wire I_CLOCK,
    input wire I_RST_B,
    input wire [`ADDR_W-1:0] I_ADDR,
    input wire [`DATA_W-1:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output reg [`DATA_W-1:0] O_RDATA,
    input wire [7:0] I_AMP1,
    input wire [7:0] I_AMP2,
    input wire [7:0] I_AMP3,
    input wire I_CONV_START,
    input wire [`EXP_IDX_W-1:0] I_CONV_EXPOSURE,
    input wire [5:0] I_CHIP_CODE,
    output reg [5:0] O_DAC_CODE,
    output reg O_DAC_SW_CONTROL,
    output reg [`CURRENT_W-1:0] O_EMITTER1_CURRENT,
    output reg [`CURRENT_W-1:0] O_EMITTER2_CURRENT,
    output reg [`CURRENT_W-1:0] O_EMITTER3_CURRENT,
    output reg [5:0] O_EMITTER_RANGE
);
    reg [`DATA_W-1:0] range_ff;
    reg [`DATA_W-1:0] ovr_ff [0:`NUM_EXPOSURES-1];
    reg [`DATA_W-1:0] nxt_rdata;
    reg [`DATA_W-1:0] sel_ovr;
    reg conv_valid;
    wire conv_take;
    wire [1:0] range1;
    wire [1:0] range2;
    wire [1:0] range3;
    wire [1:0] full_scale1;
    wire [1:0] full_scale2;
    wire [1:0] full_scale3;
    wire [`CURRENT_W-1:0] cur1;
    wire [`CURRENT_W-1:0] cur2;
    wire [`CURRENT_W-1:0] cur3;
    integer k;

    // Each driver sees only its own two-bit field of the range register
    assign range1 = range_ff[`RANGE1_LSB+1:`RANGE1_LSB];
    assign range2 = range_ff[`RANGE2_LSB+1:`RANGE2_LSB];
    assign range3 = range_ff[`RANGE3_LSB+1:`RANGE3_LSB];

    // A start with exposure 0 or 7 is no conversion and changes nothing
    assign conv_take = I_CONV_START && conv_valid;

    always @(posedge I_CLOCK)
    begin
        if (!I_RST_B)
        begin
            range_ff <= `RST_BYTE;
            for (k = 0; k < `NUM_EXPOSURES; k = k + 1)
                ovr_ff[k] <= `RST_BYTE;
        end
        else if (I_WR)
        begin
            // Reserved bits are dropped here so that reads return 0
            if (I_ADDR == `OFS_EMITTER_RANGE)
                range_ff <= I_WDATA & `RANGE_MASK;
            else if (I_ADDR == `OFS_EXP1_OVERRIDE)
                ovr_ff[`SLOT1] <= I_WDATA & `OVR_MASK;
            else if (I_ADDR == `OFS_EXP2_OVERRIDE)
                ovr_ff[`SLOT2] <= I_WDATA & `OVR_MASK;
            else if (I_ADDR == `OFS_EXP3_OVERRIDE)
                ovr_ff[`SLOT3] <= I_WDATA & `OVR_MASK;
            else if (I_ADDR == `OFS_EXP4_OVERRIDE)
                ovr_ff[`SLOT4] <= I_WDATA & `OVR_MASK;
            else if (I_ADDR == `OFS_EXP5_OVERRIDE)
                ovr_ff[`SLOT5] <= I_WDATA & `OVR_MASK;
            else if (I_ADDR == `OFS_EXP6_OVERRIDE)
                ovr_ff[`SLOT6] <= I_WDATA & `OVR_MASK;
        end
    end

    always @*
    begin
        if (I_ADDR == `OFS_EMITTER_RANGE)
            nxt_rdata = range_ff;
        else if (I_ADDR == `OFS_EXP1_OVERRIDE)
            nxt_rdata = ovr_ff[`SLOT1];
        else if (I_ADDR == `OFS_EXP2_OVERRIDE)
            nxt_rdata = ovr_ff[`SLOT2];
        else if (I_ADDR == `OFS_EXP3_OVERRIDE)
            nxt_rdata = ovr_ff[`SLOT3];
        else if (I_ADDR == `OFS_EXP4_OVERRIDE)
            nxt_rdata = ovr_ff[`SLOT4];
        else if (I_ADDR == `OFS_EXP5_OVERRIDE)
            nxt_rdata = ovr_ff[`SLOT5];
        else if (I_ADDR == `OFS_EXP6_OVERRIDE)
            nxt_rdata = ovr_ff[`SLOT6];
        else
            nxt_rdata = `RST_BYTE;
    end

    // Exposure numbers count from 1; decoding them one by one keeps
    // exposures 0 and 7 from ever indexing past the six slots
    always @*
    begin
        sel_ovr = `RST_BYTE;
        conv_valid = 1'b0;
        case (I_CONV_EXPOSURE)
            `EXP_NUM1:
            begin
                sel_ovr = ovr_ff[`SLOT1];
                conv_valid = 1'b1;
            end
            `EXP_NUM2:
            begin
                sel_ovr = ovr_ff[`SLOT2];
                conv_valid = 1'b1;
            end
            `EXP_NUM3:
            begin
                sel_ovr = ovr_ff[`SLOT3];
                conv_valid = 1'b1;
            end
            `EXP_NUM4:
            begin
                sel_ovr = ovr_ff[`SLOT4];
                conv_valid = 1'b1;
            end
            `EXP_NUM5:
            begin
                sel_ovr = ovr_ff[`SLOT5];
                conv_valid = 1'b1;
            end
            `EXP_NUM6:
            begin
                sel_ovr = ovr_ff[`SLOT6];
                conv_valid = 1'b1;
            end
            default:
            begin
                sel_ovr = `RST_BYTE;
                conv_valid = 1'b0;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge I_CLOCK)
    begin
        if (!I_RST_B)
            O_RDATA <= `RST_BYTE;
        else if (I_RD)
            O_RDATA <= nxt_rdata;
        else
            O_RDATA <= `RST_BYTE;
    end

    // Latched at conversion start so mid-conversion writes cannot glitch it
    always @(posedge I_CLOCK)
    begin
        if (!I_RST_B)
        begin
            O_DAC_CODE <= `DAC_RST;
            O_DAC_SW_CONTROL <= `SW_RST;
        end
        else if (conv_take)
        begin
            O_DAC_SW_CONTROL <= sel_ovr[`OVR_BIT];
            if (sel_ovr[`OVR_BIT])
                O_DAC_CODE <= sel_ovr[`CODE_MSB:0];
            else
                O_DAC_CODE <= I_CHIP_CODE;
        end
    end

    emitter_current_calc u_drv1
    (
        .i_range(range1),
        .i_amplitude(I_AMP1),
        .o_current_units(cur1),
        .o_full_scale_units(full_scale1)
    );

    emitter_current_calc u_drv2
    (
        .i_range(range2),
        .i_amplitude(I_AMP2),
        .o_current_units(cur2),
        .o_full_scale_units(full_scale2)
    );

    emitter_current_calc u_drv3
    (
        .i_range(range3),
        .i_amplitude(I_AMP3),
        .o_current_units(cur3),
        .o_full_scale_units(full_scale3)
    );

    // Registered so each output is a flop; currents lag inputs one cycle

    always @(posedge I_CLOCK)
    begin
        if (!I_RST_B)
        begin
            O_EMITTER1_CURRENT <= {`CURRENT_W{1'b0}};
            O_EMITTER2_CURRENT <= {`CURRENT_W{1'b0}};
            O_EMITTER3_CURRENT <= {`CURRENT_W{1'b0}};
            O_EMITTER_RANGE <= `RANGE_RST;
        end
        else
        begin
            O_EMITTER1_CURRENT <= cur1;
            O_EMITTER2_CURRENT <= cur2;
            O_EMITTER3_CURRENT <= cur3;
            O_EMITTER_RANGE <= {full_scale3, full_scale2, full_scale1};
        end
    end
endmodule // emitter_range_regs
`default_nettype wire

/* verification/emitter_range_checker.sv */
// Checker for the range and subrange override register block
// Assumes it is bound to the top module's ports, one clock domain
`timescale 1ns/100ps
`default_nettype none
module emitter_range_checker
(
    input wire logic I_CLOCK,
    input wire logic I_RST_B,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] O_RDATA,
    input wire logic [7:0] I_AMP1,
    input wire logic I_CONV_START,
    input wire logic [2:0] I_CONV_EXPOSURE,
    input wire logic [5:0] I_CHIP_CODE,
    input wire logic [5:0] O_DAC_CODE,
    input wire logic O_DAC_SW_CONTROL,
    input wire logic [10:0] O_EMITTER1_CURRENT,
    input wire logic [5:0] O_EMITTER_RANGE
);
default clocking @(posedge I_CLOCK); endclocking
default disable iff (!I_RST_B);
// Exposures 0 and 7 do not start a conversion
wire cs = I_CONV_START && (I_CONV_EXPOSURE inside {[1:6]});
wire rw = I_WR && I_ADDR == 8'h2a;
a_range_cause: assert property ($changed(O_EMITTER_RANGE) |->
    $past(rw) || $past(rw, 2)) else $error("range moved without write");
a_chip_code: assert property (cs ##1 !O_DAC_SW_CONTROL |->
    O_DAC_CODE == $past(I_CHIP_CODE)) else $error("chip code not used");
a_dac_hold: assert property (!cs |=> $stable(O_DAC_CODE) &&
    $stable(O_DAC_SW_CONTROL)) else $error("dac moved mid conversion");
a_current_calc: assert property ((!I_WR && $stable(I_AMP1))[*3] |->
    O_EMITTER1_CURRENT == I_AMP1 * (O_EMITTER_RANGE[1:0] + 1))
    else $error("emitter current wrong");
a_range_write: assert property (rw |-> ##2 O_EMITTER_RANGE ==
    $past(I_WDATA[5:0], 2)) else $error("range field not applied");
a_bad_exposure: assert property (I_CONV_START && !cs |=>
    $stable(O_DAC_CODE) && $stable(O_DAC_SW_CONTROL))
    else $error("dac moved on invalid exposure");
a_rdata_idle: assert property (!I_RD |=> O_RDATA == 8'h00)
    else $error("read data outside read cycle");
endmodule // emitter_range_checker
`default_nettype wire

/* verification/emitter_range_and_dac_override_regs_bench.sv */
// Bench for the range and subrange override register block
// Assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module emitter_range_and_dac_override_regs_bench;
logic clk = 0, rst_b = 0, wr = 0, rd = 0, cs = 0, sw;
logic [7:0] ad = 0, wd = 0, a1 = 0, a2 = 0, a3 = 0, rdat, d, x = 0;
logic [7:0] rv [8'h2a:8'h31];
logic [5:0] chip = 0, dac, rng;
logic [2:0] ex = 0, e;
logic [10:0] c1, c2, c3;
int n_errors = 0, num_checks = 0;
emitter_range_regs i_emitter_range_regs (.I_CLOCK(clk), .I_RST_B(rst_b),
    .I_ADDR(ad), .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdat),
    .I_AMP1(a1), .I_AMP2(a2), .I_AMP3(a3), .I_CONV_START(cs),
    .I_CONV_EXPOSURE(ex), .I_CHIP_CODE(chip), .O_DAC_CODE(dac),
    .O_DAC_SW_CONTROL(sw), .O_EMITTER1_CURRENT(c1),
    .O_EMITTER2_CURRENT(c2), .O_EMITTER3_CURRENT(c3),
    .O_EMITTER_RANGE(rng));
initial
begin
    forever #50 clk = ~clk;
end
// Unused bits read 0; 0x2b is unmapped and keeps nothing
function [7:0] msk(input [7:0] a, v);
    return a == 8'h2a ? v & 8'h3f : a == 8'h2b ? 8'h00 : v & 8'hbf;
endfunction
function [10:0] cur(input [7:0] a, input [1:0] r);
    return a * (r + 3'd1);
endfunction
task chk(input string n, input logic [10:0] s, e);
    num_checks++;
    if (s !== e)
    begin
        n_errors++;
        $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
endtask
task wr_reg(input [7:0] a, v);
    @(posedge clk);
    wr <= 1;
    ad <= a;
    wd <= v;
    @(posedge clk);
    wr <= 0;
    rv[a] = msk(a, v);
endtask
task rd_reg(input [7:0] a);
    @(posedge clk);
    rd <= 1;
    ad <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", rdat, rv[a]);
    @(posedge clk);
    #1 chk("rdata idle", rdat, 8'h00);
endtask
task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
initial
begin
    void'($urandom(32'hd18db2c5));
    foreach (rv[i])
        rv[i] = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1;
    for (int i = 8'h2a; i < 8'h32; i++)
        rd_reg(i);
    $display("reset values done");
    // First pass all ones: every override on, full range, top amplitude on emitter 2 only
    for (int k = 0; k < 32; k++)
    begin
        e = k % 8;
        wr_reg(8'h2a + e, k < 8 ? 8'hff : $urandom);
        rd_reg(8'h2a + e);
        @(posedge clk);
        cs <= 1;
        ex <= e;
        d = $urandom;
        chip <= d[5:0];
        @(posedge clk);
        cs <= 0;
        a1 <= $urandom;
        a2 <= k < 8 ? 8'hff : $urandom;
        a3 <= $urandom;
        if (e != 0 && e != 7)
            x = rv[8'h2b + e][7] ? rv[8'h2b + e] : {2'b00, d[5:0]};
        #1 chk("dac", dac, x[5:0]);
        chk("sw", sw, x[7]);
        repeat (2) @(posedge clk);
        #1 chk("range", rng, rv[8'h2a][5:0]);
        chk("cur1", c1, cur(a1, rv[8'h2a][1:0]));
        chk("cur2", c2, cur(a2, rv[8'h2a][3:2]));
        chk("cur3", c3, cur(a3, rv[8'h2a][5:4]));
    end
    $display("random loop done");
    // Write and start in one cycle: the conversion takes the old setting
    @(posedge clk);
    wr <= 1;
    ad <= 8'h2c;
    wd <= 8'h85;
    cs <= 1;
    ex <= 1;
    chip <= 6'h2a;
    @(posedge clk);
    wr <= 0;
    cs <= 0;
    x = rv[8'h2c][7] ? rv[8'h2c] : 8'h2a;
    rv[8'h2c] = 8'h85;
    #1 chk("dac old", dac, x[5:0]);
    chk("sw old", sw, x[7]);
    @(posedge clk);
    cs <= 1;
    @(posedge clk);
    cs <= 0;
    #1 chk("dac new", dac, 6'h05);
    chk("sw new", sw, 1'b1);
    $display("write during start done");
    // Mid-run reset: outputs and registers return to zero
    @(posedge clk);
    rst_b <= 0;
    repeat (4) @(posedge clk);
    rst_b <= 1;
    #1 chk("dac rst", dac, 6'h00);
    chk("sw rst", sw, 1'b0);
    chk("range rst", rng, 6'h00);
    chk("cur1 rst", c1, 11'h000);
    foreach (rv[i])
        rv[i] = 0;
    for (int i = 8'h2a; i < 8'h32; i++)
        rd_reg(i);
    $display("mid-run reset done");
    end_of_test();
end
endmodule // emitter_range_and_dac_override_regs_bench
bind emitter_range_regs emitter_range_checker i_emitter_range_checker (.*);
`default_nettype wire
